// [bench/vfd_serial_shift_latch_driver_bench.sv]
`timescale 1ns/1ps

module vfd_serial_shift_latch_driver_bench;
  localparam int unsigned N    = vsd_pkg::STAGES;
  localparam logic [39:0] W_A  = 40'ha5_0f3c_9601;
  localparam logic [39:0] W_B  = 40'h3c_e1d2_5a7e;
  localparam logic [39:0] W_C  = 40'h80_0000_0001;

  logic         i_clock;
  logic         i_reset;
  logic         i_latch_strobe;
  logic         i_blank_n;
  logic         i_force_all_on;
  logic         shift_clock;
  logic         serial_in;
  logic         shift_dir;
  logic         serial_out;
  logic [N-1:0] drive_out;
  logic [N-1:0] latched_bit;
  logic [N-1:0] got;
  int           miscompares;
  int           compares;

  initial i_clock = 1'b0;
  always #(vsd_pkg::CLOCK_PERIOD_NS / 2) i_clock = ~i_clock;

  vsd_driver #(.STAGES(N)) dut (
    .i_clock        (i_clock),
    .i_reset        (i_reset),
    .i_shift_clock  (shift_clock),
    .i_serial_in    (serial_in),
    .i_shift_dir    (shift_dir),
    .o_serial_out   (serial_out),
    .i_latch_strobe (i_latch_strobe),
    .i_blank_n      (i_blank_n),
    .i_force_all_on (i_force_all_on),
    .o_drive_out    (drive_out),
    .o_latched_bit  (latched_bit)
  );

  vsd_host host (
    .o_shift_clock (shift_clock),
    .o_serial_in   (serial_in),
    .o_shift_dir   (shift_dir),
    .i_serial_out  (serial_out)
  );

  task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Generous settle: pins take 3 core cycles, the mirror 3 after a shift edge
  task automatic pins(input logic ls, input logic bn, input logic fo);
    @(posedge i_clock);
    i_latch_strobe <= ls;
    i_blank_n      <= bn;
    i_force_all_on <= fo;
    repeat (8) @(posedge i_clock);
  endtask : pins

  task automatic t_load_show;
    host.send_word(W_A, 1'b1, got);
    pins(1'b1, 1'b0, 1'b0);
    chk(latched_bit, W_A);
    chk(drive_out, '0);
    pins(1'b1, 1'b1, 1'b0);
    chk(drive_out, W_A);
  endtask : t_load_show

  task automatic t_hold_reverse;
    pins(1'b0, 1'b1, 1'b0);
    host.send_word(W_B, 1'b0, got);
    chk(got, W_A);
    repeat (8) @(posedge i_clock);
    chk(latched_bit, W_A);
    chk(drive_out, W_A);
    pins(1'b1, 1'b1, 1'b0);
    chk(latched_bit, W_B);
  endtask : t_hold_reverse

  task automatic t_cascade_edges;
    host.send_word(W_C, 1'b1, got);
    chk(got, W_B);
    pins(1'b1, 1'b1, 1'b0);
    chk(drive_out, W_C);
  endtask : t_cascade_edges

  task automatic t_gating;
    pins(1'b1, 1'b1, 1'b1);
    chk(drive_out, '1);
    pins(1'b1, 1'b0, 1'b1);
    chk(drive_out, '0);
    pins(1'b1, 1'b1, 1'b0);
    chk(drive_out, W_C);
  endtask : t_gating

  initial begin
    miscompares    = 0;
    compares       = 0;
    i_reset        = 1'b1;
    i_latch_strobe = 1'b0;
    i_blank_n      = 1'b0; // Display kept blank until data is
    i_force_all_on = 1'b0;
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk(drive_out, '0);
    t_load_show();
    t_hold_reverse();
    t_cascade_edges();
    t_gating();
    close_out();
  end

  // Three words of 1.3 us each plus settling stay well below this span
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule : vfd_serial_shift_latch_driver_bench

// [bench/vsd_host.sv]
`timescale 1ns/1ps

// Controller model: shift clock stands low outside frames, 32 ns period inside them
module vsd_host (
  // Link pins toward the driver
  output logic      o_shift_clock,
  output logic      o_serial_in,
  output logic      o_shift_dir,
  // Cascade output from the driver
  input  wire logic i_serial_out
);
  localparam int unsigned HALF_NS  = 16;
  localparam int unsigned PHASE_NS = 3;

  initial begin
    o_shift_clock = 1'b0;
    o_serial_in   = 1'b0;
    o_shift_dir   = 1'b1; // Open direction pin reads high
  end

  // Order chosen so every bit sits at its own index after 40 edges
  task automatic send_word(input  logic [vsd_pkg::STAGES-1:0] w,
                           input  logic                       dir,
                           output logic [vsd_pkg::STAGES-1:0] got);
    int unsigned idx;
    o_shift_dir = dir;
    // Frames start off the core clock grid so every shift edge falls 3 ns after a core rising edge
    #PHASE_NS;
    for (int k = 0; k < vsd_pkg::STAGES; k++) begin
      idx = dir ? vsd_pkg::STAGES - 1 - k : k;
      o_serial_in = w[idx]; // Data changes only while clock is low
      #HALF_NS;
      got[idx] = i_serial_out;
      o_shift_clock = 1'b1;
      #HALF_NS;
      o_shift_clock = 1'b0;
    end
    // Released line has no pull: show the inverse so a stale sample cannot pass
    o_serial_in = ~o_serial_in;
  endtask : send_word
endmodule : vsd_host

// [hw/vsd_driver.sv]
`timescale 1ns/1ps

module vsd_driver #(
  parameter int unsigned STAGES = vsd_pkg::STAGES
) (
  // Core clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Serial link, timed by the controller's shift clock
  input  wire logic              i_shift_clock,
  input  wire logic              i_serial_in,
  input  wire logic              i_shift_dir,
  output logic                   o_serial_out,
  // Latch and output control pins
  input  wire logic              i_latch_strobe,
  input  wire logic              i_blank_n,
  input  wire logic              i_force_all_on,
  // Display side
  output logic      [STAGES-1:0] o_drive_out,
  output logic      [STAGES-1:0] o_latched_bit
);

  // Index 0 is stage 1, index STAGES-1 is the last stage
  logic [STAGES-1:0] shift_stage_r;
  logic [STAGES-1:0] shift_stage_nxt;
  logic              toggle_r;

  logic [STAGES-1:0] mirror_word;
  logic              mirror_update;

  vsd_pkg::vsd_pins_t pins_raw;
  vsd_pkg::vsd_pins_t pins_meta_r;
  vsd_pkg::vsd_pins_t pins_sync_r;

  logic [STAGES-1:0] latched_bit_r;
  logic [STAGES-1:0] drive_out_r;
  logic [STAGES-1:0] drive_out_nxt;

  // Shift clock domain

  // Serial data is sampled straight on the shift clock edge; the controller owns setup
  always_comb begin
    if (i_shift_dir) begin
      shift_stage_nxt = {shift_stage_r[STAGES-2:0], i_serial_in};
    end else begin
      shift_stage_nxt = {i_serial_in, shift_stage_r[STAGES-1:1]};
    end
  end

  // No reset here: the power-up pattern is arbitrary, hence blanking at start-up
  // Checks below use case equality, as stages stay unknown until a full word is in
  always_ff @(posedge i_shift_clock) begin
    shift_stage_r <= shift_stage_nxt;
  end

  // Cascade output follows the stage that would fall off the far end
  assign o_serial_out = i_shift_dir ? shift_stage_r[STAGES-1]
                                    : shift_stage_r[0];

  // One flip per shift edge tells the core domain that a new word stands
  always_ff @(posedge i_shift_clock or posedge i_reset) begin
    if (i_reset) begin
      toggle_r <= vsd_pkg::TOGGLE_RESET;
    end else begin
      toggle_r <= ~toggle_r;
    end
  end

  // Crossing into the core domain

  vsd_word_sync #(
    .WIDTH (STAGES)
  ) u_word_sync (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_toggle (toggle_r),
    .i_word   (shift_stage_r),
    .o_word   (mirror_word),
    .o_update (mirror_update)
  );

  // Core clock domain

  assign pins_raw = '{
    latch_strobe: i_latch_strobe,
    blank_n:      i_blank_n,
    force_all_on: i_force_all_on
  };

  // Pads resolve to their pull levels while in reset
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pins_meta_r <= vsd_pkg::PINS_RESET;
      pins_sync_r <= vsd_pkg::PINS_RESET;
    end else begin
      pins_meta_r <= pins_raw;
      pins_sync_r <= pins_meta_r;
    end
  end

  // Transparent while the strobe is high, frozen from its falling edge on
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      latched_bit_r <= '0;
    end else if (pins_sync_r.latch_strobe) begin
      latched_bit_r <= mirror_word;
    end
  end

  assign o_latched_bit = latched_bit_r;

  // Per-output gating: blank wins over lamp test, lamp test over latch data
  for (genvar m = 0; m < STAGES; m++) begin : g_gate
    always_comb begin
      if (!pins_sync_r.blank_n) begin
        drive_out_nxt[m] = 1'b0;
      end else if (pins_sync_r.force_all_on) begin
        drive_out_nxt[m] = 1'b1;
      end else begin
        drive_out_nxt[m] = latched_bit_r[m];
      end
    end
  end

  // Registered on the core clock, so gating never waits on the shift clock
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      drive_out_r <= '0;
    end else begin
      drive_out_r <= drive_out_nxt;
    end
  end

  assign o_drive_out = drive_out_r;

  // Checks on the shift clock domain

  property p_shift_up;
    @(posedge i_shift_clock) disable iff (i_reset)
      i_shift_dir |=> (shift_stage_r[0] === $past(i_serial_in)) &&
                      (shift_stage_r[STAGES-1:1] === $past(shift_stage_r[STAGES-2:0]));
  endproperty
  a_shift_up: assert property (p_shift_up)
    else $error("upward shift did not move data toward the last stage");

  property p_shift_down;
    @(posedge i_shift_clock) disable iff (i_reset)
      !i_shift_dir |=> (shift_stage_r[STAGES-1] === $past(i_serial_in)) &&
                       (shift_stage_r[STAGES-2:0] === $past(shift_stage_r[STAGES-1:1]));
  endproperty
  a_shift_down: assert property (p_shift_down)
    else $error("downward shift did not move data toward stage one");

  property p_toggle_each_edge;
    @(posedge i_shift_clock) disable iff (i_reset)
      ##1 (toggle_r != $past(toggle_r));
  endproperty
  a_toggle_each_edge: assert property (p_toggle_each_edge)
    else $error("shift edge not signalled to the core domain");

  sequence s_up_two;
    i_shift_dir ##1 i_shift_dir;
  endsequence

  property p_cascade_up;
    @(posedge i_shift_clock) disable iff (i_reset)
      s_up_two |-> (o_serial_out === $past(shift_stage_r[STAGES-2]));
  endproperty
  a_cascade_up: assert property (p_cascade_up)
    else $error("cascade output does not carry the last stage");

  sequence s_down_two;
    !i_shift_dir ##1 !i_shift_dir;
  endsequence

  property p_cascade_down;
    @(posedge i_shift_clock) disable iff (i_reset)
      s_down_two |-> (o_serial_out === $past(shift_stage_r[1]));
  endproperty
  a_cascade_down: assert property (p_cascade_down)
    else $error("cascade output does not carry stage one");

  // Checks on the core clock domain

  property p_latch_follow;
    @(posedge i_clock) disable iff (i_reset)
      pins_sync_r.latch_strobe |=> (latched_bit_r == $past(mirror_word));
  endproperty
  a_latch_follow: assert property (p_latch_follow)
    else $error("latch not transparent while strobe is high");

  sequence s_strobe_low_two;
    !pins_sync_r.latch_strobe ##1 !pins_sync_r.latch_strobe;
  endsequence

  property p_latch_hold;
    @(posedge i_clock) disable iff (i_reset)
      s_strobe_low_two |-> $stable(latched_bit_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed while strobe is low");

  property p_blank;
    @(posedge i_clock) disable iff (i_reset)
      !pins_sync_r.blank_n |=> (o_drive_out == '0);
  endproperty
  a_blank: assert property (p_blank)
    else $error("outputs not blanked");

  property p_normal;
    @(posedge i_clock) disable iff (i_reset)
      (pins_sync_r.blank_n && !pins_sync_r.force_all_on) |=>
        (o_drive_out == $past(latched_bit_r));
  endproperty
  a_normal: assert property (p_normal)
    else $error("outputs do not follow the latch");

  property p_lamp_test;
    @(posedge i_clock) disable iff (i_reset)
      (pins_sync_r.blank_n && pins_sync_r.force_all_on) |=> (&o_drive_out);
  endproperty
  a_lamp_test: assert property (p_lamp_test)
    else $error("lamp test did not drive all outputs high");

  sequence s_pin_blank_held;
    !i_blank_n [*4];
  endsequence

  property p_pin_blank;
    @(posedge i_clock) disable iff (i_reset)
      s_pin_blank_held |-> (o_drive_out == '0);
  endproperty
  a_pin_blank: assert property (p_pin_blank)
    else $error("blank pin held low yet outputs active");

  sequence s_pin_force_held;
    (i_blank_n && i_force_all_on) [*4];
  endsequence

  property p_pin_force;
    @(posedge i_clock) disable iff (i_reset)
      s_pin_force_held |-> (&o_drive_out);
  endproperty
  a_pin_force: assert property (p_pin_force)
    else $error("lamp test pins held yet outputs not all high");

  property p_reset_defaults;
    @(posedge i_clock)
      i_reset |-> (pins_sync_r.blank_n && !pins_sync_r.force_all_on && (o_drive_out == '0));
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("pull defaults not applied in reset");

  property p_positive_logic;
    @(posedge i_clock) disable iff (i_reset)
      (pins_sync_r.blank_n && !pins_sync_r.force_all_on && latched_bit_r[0]) |=>
        o_drive_out[0];
  endproperty
  a_positive_logic: assert property (p_positive_logic)
    else $error("a one in the latch did not drive its output high");

endmodule : vsd_driver

// [hw/vsd_pkg.sv]
package vsd_pkg;

  // Geometry
  localparam int unsigned STAGES = 40;

  // Clocking of the core side
  localparam int unsigned CLOCK_PERIOD_NS = 8;

  // Power-up level each pad assumes when the controller leaves it open
  localparam logic SHIFT_DIR_DEFAULT    = 1'b1;
  localparam logic BLANK_N_DEFAULT      = 1'b1;
  localparam logic FORCE_ALL_ON_DEFAULT = 1'b0;
  localparam logic LATCH_STROBE_RESET   = 1'b0;

  // Reset value of the cross-domain toggle
  localparam logic TOGGLE_RESET = 1'b0;

  // Control pins that are resampled on the core clock
  typedef struct packed {
    logic latch_strobe;
    logic blank_n;
    logic force_all_on;
  } vsd_pins_t;

  localparam vsd_pins_t PINS_RESET = '{
    latch_strobe: LATCH_STROBE_RESET,
    blank_n:      BLANK_N_DEFAULT,
    force_all_on: FORCE_ALL_ON_DEFAULT
  };

endpackage : vsd_pkg

// [hw/vsd_word_sync.sv]
`timescale 1ns/1ps

module vsd_word_sync #(
  parameter int unsigned WIDTH = vsd_pkg::STAGES
) (
  // Core clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // Source side, from the shift clock domain
  input  wire logic             i_toggle,
  input  wire logic [WIDTH-1:0] i_word,
  // Destination side
  output logic      [WIDTH-1:0] o_word,
  output logic                  o_update
);

  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_seen_r;

  // The toggle flips once per shift edge; the word it qualifies holds until the next edge
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tog_meta_r <= vsd_pkg::TOGGLE_RESET;
      tog_sync_r <= vsd_pkg::TOGGLE_RESET;
      tog_seen_r <= vsd_pkg::TOGGLE_RESET;
    end else begin
      tog_meta_r <= i_toggle;
      tog_sync_r <= tog_meta_r;
      tog_seen_r <= tog_sync_r;
    end
  end

  assign o_update = tog_sync_r ^ tog_seen_r;

  // Capture lands within three core cycles, inside one shift period of 32 ns or more
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_word <= '0;
    end else if (o_update) begin
      o_word <= i_word;
    end
  end

  property p_word_capture;
    @(posedge i_clock) disable iff (i_reset)
      o_update |=> (o_word === $past(i_word));
  endproperty
  a_word_capture: assert property (p_word_capture)
    else $error("mirror word not captured on update");

endmodule : vsd_word_sync
